// File: design/mqs_top.sv
// How it works
// - read strobe high selects read queue
// - read switch four cycles, then reads stick
// - one read per clock, even during switch
// - switch-cycle reads still use present queue
// - never read an empty queue
// - output enable only tristates, data still loads
// - queue select: strobe, no status, id match
// - status select: status strobe, id in 7:5
// - status word picks eight consecutive queues
// - write strobe high selects write queue
// - write enable ignored, sampled for rewrite
// - write switch takes four cycles
// - switches every four cycles, any order
// - writes to present queue continue during switch
// - both ports switch independently, concurrently
// - ports may share or differ in queue
// - start, mark decision, then idle cycle
// - full flags show next queue at QS2
// - next queue writes begin at QS3
// - standard and back-off-one read modes
// - back-off-one re-presents last read word
// - never write a full queue
`timescale 1ns/100ps
`default_nettype none

module mqs_top (
    input  wire logic                         I_CLK_SYS,
    input  wire logic                         I_RST,
    input  wire logic                         I_CE,
    input  wire logic                         I_BACK_OFF_ONE_MODE,
    input  wire logic [mqs_pkg::DEV_W-1:0]    I_DEVICE_IDENTITY_PINS,
    input  wire logic [mqs_pkg::ADDR_W-1:0]   I_WRITE_QUEUE_ADDRESS_BUS,
    input  wire logic                         I_WRITE_ADDRESS_STROBE,
    input  wire logic                         I_WR_EN_N,
    input  wire logic [mqs_pkg::DATA_W-1:0]   I_WR_DATA,
    input  wire logic [mqs_pkg::ADDR_W-1:0]   I_READ_QUEUE_ADDRESS_BUS,
    input  wire logic                         I_READ_ADDRESS_STROBE,
    input  wire logic                         I_EMPTY_STATUS_STROBE,
    input  wire logic                         I_RD_EN_N,
    input  wire logic                         I_RD_OUT_EN_N,
    output logic [mqs_pkg::DATA_W-1:0]        O_RD_DATA,
    output logic                              O_RD_DATA_VALID,
    output logic                              O_RD_DATA_OE_N,
    output logic                              O_EMPTY_FLAG,
    output logic                              O_FULL_FLAG,
    output logic                              O_ALMOST_FULL_FLAG,
    output logic [mqs_pkg::GROUP_W-1:0]       O_ALMOST_EMPTY_STATUS_BUS,
    output logic                              O_WR_MARK,
    output logic                              O_RD_MARK
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [mqs_pkg::NUM_QUEUES-1:0][3:0][mqs_pkg::DATA_W-1:0] mem;
        logic [mqs_pkg::NUM_QUEUES-1:0][mqs_pkg::DATA_W-1:0]      last_word;
        logic [mqs_pkg::NUM_QUEUES-1:0][mqs_pkg::PTR_W-1:0]       wr_ptr;
        logic [mqs_pkg::NUM_QUEUES-1:0][mqs_pkg::PTR_W-1:0]       rd_ptr;
        logic [mqs_pkg::DATA_W-1:0]                               rd_data;
        logic                                                     rd_valid;
        logic                                                     boi_pending;
        logic [mqs_pkg::STAT_W-1:0]                               stat_word;
        logic [mqs_pkg::GROUP_W-1:0]                              ae_bus;
    } mqs_core_t;

    mqs_core_t core_reg;
    mqs_core_t core_next;

    logic                        wr_select;
    logic                        rd_select;
    logic                        stat_select;
    logic                        wr_busy;
    logic                        wr_update;
    logic                        wr_commit;
    logic [mqs_pkg::QUEUE_W-1:0] wr_q;
    logic [mqs_pkg::QUEUE_W-1:0] wr_flag_q;
    logic                        rd_busy;
    logic                        rd_update;
    logic                        rd_commit;
    logic [mqs_pkg::QUEUE_W-1:0] rd_q;
    logic [mqs_pkg::QUEUE_W-1:0] rd_flag_q;

    function automatic logic [mqs_pkg::PTR_W-1:0] fill_of(
        input mqs_core_t              c,
        input logic [mqs_pkg::QUEUE_W-1:0] q
    );
        fill_of = c.wr_ptr[q] - c.rd_ptr[q];
    endfunction : fill_of

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign wr_select = I_WRITE_ADDRESS_STROBE
        & (I_WRITE_QUEUE_ADDRESS_BUS[mqs_pkg::QSEL_DEV_LSB +: mqs_pkg::DEV_W]
           == I_DEVICE_IDENTITY_PINS);
    assign rd_select = I_READ_ADDRESS_STROBE & ~I_EMPTY_STATUS_STROBE
        & (I_READ_QUEUE_ADDRESS_BUS[mqs_pkg::QSEL_DEV_LSB +: mqs_pkg::DEV_W]
           == I_DEVICE_IDENTITY_PINS);
    assign stat_select = ~I_READ_ADDRESS_STROBE & I_EMPTY_STATUS_STROBE
        & (I_READ_QUEUE_ADDRESS_BUS[mqs_pkg::STAT_DEV_LSB +: mqs_pkg::DEV_W]
           == I_DEVICE_IDENTITY_PINS);

    // ------------------------------------------------------------
    // independent switch sequencers, one per port
    // ------------------------------------------------------------
    mqs_switch u_wr_switch (
        .i_clk       (I_CLK_SYS),
        .i_rst       (I_RST),
        .i_ce        (I_CE),
        .i_strobe    (I_WRITE_ADDRESS_STROBE),
        .i_select    (wr_select),
        .i_addr_q    (I_WRITE_QUEUE_ADDRESS_BUS[mqs_pkg::QSEL_QUEUE_LSB +: mqs_pkg::QUEUE_W]),
        .i_en_n      (I_WR_EN_N),
        .o_busy      (wr_busy),
        .o_update    (wr_update),
        .o_mark      (O_WR_MARK),
        .o_commit    (wr_commit),
        .o_present_q (wr_q),
        .o_next_q    (),
        .o_flag_q    (wr_flag_q)
    );

    mqs_switch u_rd_switch (
        .i_clk       (I_CLK_SYS),
        .i_rst       (I_RST),
        .i_ce        (I_CE),
        .i_strobe    (I_READ_ADDRESS_STROBE),
        .i_select    (rd_select),
        .i_addr_q    (I_READ_QUEUE_ADDRESS_BUS[mqs_pkg::QSEL_QUEUE_LSB +: mqs_pkg::QUEUE_W]),
        .i_en_n      (I_RD_EN_N),
        .o_busy      (rd_busy),
        .o_update    (rd_update),
        .o_mark      (O_RD_MARK),
        .o_commit    (rd_commit),
        .o_present_q (rd_q),
        .o_next_q    (),
        .o_flag_q    (rd_flag_q)
    );

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    always_comb begin
        logic                        wr_ok;
        logic                        rd_ok;
        logic [mqs_pkg::QUEUE_W-1:0] grp_q;
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        grp_q = mqs_pkg::RST_QUEUE;
        core_next          = core_reg;
        core_next.rd_valid = 1'b0;

        // write: present queue until the sequencer commits
        wr_ok = ~I_WR_EN_N & (fill_of(core_reg, wr_q) != mqs_pkg::QUEUE_DEPTH);
        if (wr_ok) begin
            core_next.mem[wr_q][core_reg.wr_ptr[wr_q][mqs_pkg::SLOT_W-1:0]] = I_WR_DATA;
            // discarded-on-return writes keep the pointer still
            if (!wr_busy || wr_update) begin
                core_next.wr_ptr[wr_q] = core_reg.wr_ptr[wr_q] + 3'h1;
            end
        end

        // read: one word per clock, also across the switch
        if (core_reg.boi_pending) begin
            core_next.rd_data     = core_reg.last_word[rd_q];
            core_next.rd_valid    = 1'b1;
            core_next.boi_pending = 1'b0;
        end else begin
            rd_ok = ~I_RD_EN_N & (fill_of(core_reg, rd_q) != 3'h0);
            if (rd_ok) begin
                core_next.rd_data = core_reg.mem[rd_q][core_reg.rd_ptr[rd_q][mqs_pkg::SLOT_W-1:0]];
                core_next.rd_valid = 1'b1;
                if (!rd_busy || rd_update) begin
                    core_next.rd_ptr[rd_q]    = core_reg.rd_ptr[rd_q] + 3'h1;
                    core_next.last_word[rd_q] = core_reg.mem[rd_q][core_reg.rd_ptr[rd_q][mqs_pkg::SLOT_W-1:0]];
                end
            end
        end
        if (rd_commit && I_BACK_OFF_ONE_MODE) begin
            core_next.boi_pending = 1'b1;
        end

        // almost-empty status word
        if (stat_select) begin
            core_next.stat_word = I_READ_QUEUE_ADDRESS_BUS[mqs_pkg::STAT_WORD_LSB +: mqs_pkg::STAT_W];
        end
        for (int i = 0; i < mqs_pkg::GROUP_W; i++) begin
            grp_q = {core_next.stat_word, i[2:0]};
            core_next.ae_bus[i] = (fill_of(core_reg, grp_q) <= mqs_pkg::ALMOST_EMPTY_LVL);
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            core_reg <= '0;
        end else if (I_CE) begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_RD_DATA                 = core_reg.rd_data;
    assign O_RD_DATA_VALID           = core_reg.rd_valid;
    assign O_RD_DATA_OE_N            = I_RD_OUT_EN_N;
    assign O_ALMOST_EMPTY_STATUS_BUS = core_reg.ae_bus;
    // flag queue moves to the next queue at QS2
    assign O_FULL_FLAG        = (fill_of(core_reg, wr_flag_q) == mqs_pkg::QUEUE_DEPTH);
    assign O_ALMOST_FULL_FLAG = (fill_of(core_reg, wr_flag_q) >= mqs_pkg::ALMOST_FULL_LVL);
    assign O_EMPTY_FLAG       = (fill_of(core_reg, rd_flag_q) == 3'h0);

    // wr_commit only marks the QS2 cycle; writes follow wr_q from QS3 on
    logic unused_commit;
    assign unused_commit = wr_commit;

endmodule : mqs_top

`default_nettype wire

// File: common/mqs_pkg.sv
package mqs_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_QUEUES = 128;
    localparam int QUEUE_W    = 7;
    localparam int DATA_W     = 40;
    localparam int SLOT_W     = 2;
    localparam int PTR_W      = 3;
    localparam int ADDR_W     = 10;
    localparam int DEV_W      = 3;
    localparam int STAT_W     = 4;
    localparam int GROUP_W    = 8;

    // ------------------------------------------------------------
    // address bus field positions
    // ------------------------------------------------------------
    localparam int QSEL_QUEUE_LSB = 0;
    localparam int QSEL_DEV_LSB   = 7;
    localparam int STAT_WORD_LSB  = 0;
    localparam int STAT_DEV_LSB   = 5;

    // ------------------------------------------------------------
    // queue fill levels
    // ------------------------------------------------------------
    localparam logic [PTR_W-1:0] QUEUE_DEPTH     = 3'h4;
    localparam logic [PTR_W-1:0] ALMOST_FULL_LVL = 3'h3;
    localparam logic [PTR_W-1:0] ALMOST_EMPTY_LVL = 3'h1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [QUEUE_W-1:0] RST_QUEUE     = 7'h00;
    localparam logic [STAT_W-1:0]  RST_STAT_WORD = 4'h0;

    // ------------------------------------------------------------
    // queue switch sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_QS0  = 2'b01,
        SW_QS1  = 2'b10,
        SW_QS2  = 2'b11
    } mqs_sw_state_t;

    typedef struct packed {
        mqs_sw_state_t        state;
        logic [QUEUE_W-1:0]   present_q;
        logic [QUEUE_W-1:0]   next_q;
        logic [QUEUE_W-1:0]   flag_q;
        logic                 update;
        logic                 mark;
    } mqs_sw_t;

endpackage : mqs_pkg

// File: design/mqs_switch.sv
`timescale 1ns/100ps
`default_nettype none

module mqs_switch (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_ce,
    input  wire logic                         i_strobe,
    input  wire logic                         i_select,
    input  wire logic [mqs_pkg::QUEUE_W-1:0]  i_addr_q,
    input  wire logic                         i_en_n,
    output logic                              o_busy,
    output logic                              o_update,
    output logic                              o_mark,
    output logic                              o_commit,
    output logic [mqs_pkg::QUEUE_W-1:0]       o_present_q,
    output logic [mqs_pkg::QUEUE_W-1:0]       o_next_q,
    output logic [mqs_pkg::QUEUE_W-1:0]       o_flag_q
);

    mqs_pkg::mqs_sw_t sw_reg;
    mqs_pkg::mqs_sw_t sw_next;

    // ------------------------------------------------------------
    // switch sequence
    // ------------------------------------------------------------
    always_comb begin
        sw_next = sw_reg;
        unique case (sw_reg.state)
            mqs_pkg::SW_IDLE: begin
                if (i_select) begin
                    // strobe alone selects, enable only picks keep/discard
                    sw_next.state  = mqs_pkg::SW_QS0;
                    sw_next.next_q = i_addr_q;
                    sw_next.update = ~i_en_n;
                end
            end
            mqs_pkg::SW_QS0: begin
                sw_next.mark  = i_strobe;
                sw_next.state = mqs_pkg::SW_QS1;
            end
            mqs_pkg::SW_QS1: begin
                sw_next.flag_q = sw_reg.next_q;
                sw_next.state  = mqs_pkg::SW_QS2;
            end
            mqs_pkg::SW_QS2: begin
                sw_next.present_q = sw_reg.next_q;
                sw_next.state     = mqs_pkg::SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sw_reg.state     <= mqs_pkg::SW_IDLE;
            sw_reg.present_q <= mqs_pkg::RST_QUEUE;
            sw_reg.next_q    <= mqs_pkg::RST_QUEUE;
            sw_reg.flag_q    <= mqs_pkg::RST_QUEUE;
            sw_reg.update    <= 1'b0;
            sw_reg.mark      <= 1'b0;
        end else if (i_ce) begin
            sw_reg <= sw_next;
        end
    end

    assign o_busy      = (sw_reg.state != mqs_pkg::SW_IDLE);
    assign o_update    = sw_reg.update;
    assign o_mark      = sw_reg.mark;
    assign o_commit    = (sw_reg.state == mqs_pkg::SW_QS2);
    assign o_present_q = sw_reg.present_q;
    assign o_next_q    = sw_reg.next_q;
    assign o_flag_q    = sw_reg.flag_q;

endmodule : mqs_switch

`default_nettype wire

// File: test/mqs_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module mqs_top_sva (
    input wire logic                       I_CLK_SYS,
    input wire logic                       I_RST,
    input wire logic [mqs_pkg::DEV_W-1:0]  I_DEVICE_IDENTITY_PINS,
    input wire logic [mqs_pkg::ADDR_W-1:0] I_WRITE_QUEUE_ADDRESS_BUS,
    input wire logic                       I_WRITE_ADDRESS_STROBE,
    input wire logic [mqs_pkg::ADDR_W-1:0] I_READ_QUEUE_ADDRESS_BUS,
    input wire logic                       I_READ_ADDRESS_STROBE,
    input wire logic                       I_EMPTY_STATUS_STROBE,
    input wire logic                       I_RD_EN_N,
    input wire logic                       I_RD_OUT_EN_N,
    input wire logic                       I_BACK_OFF_ONE_MODE,
    input wire logic                       O_RD_DATA_VALID,
    input wire logic                       O_RD_DATA_OE_N,
    input wire logic                       O_EMPTY_FLAG,
    input wire logic                       O_FULL_FLAG,
    input wire logic                       O_ALMOST_FULL_FLAG,
    input wire logic                       O_WR_MARK,
    input wire logic                       O_RD_MARK
);
    // ------------------------------------------------------------
    // switch cycle counters, 1..3 = QS0..QS2
    // ------------------------------------------------------------
    logic [1:0] w_cnt;
    logic [1:0] r_cnt;
    logic       w_take;
    logic       r_take;
    assign w_take = I_WRITE_ADDRESS_STROBE && w_cnt == 2'h0
                    && I_WRITE_QUEUE_ADDRESS_BUS[9:7] == I_DEVICE_IDENTITY_PINS;
    assign r_take = I_READ_ADDRESS_STROBE && !I_EMPTY_STATUS_STROBE && r_cnt == 2'h0
                    && I_READ_QUEUE_ADDRESS_BUS[9:7] == I_DEVICE_IDENTITY_PINS;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            w_cnt <= 2'h0;
            r_cnt <= 2'h0;
        end else begin
            w_cnt <= (w_take || w_cnt != 2'h0) ? w_cnt + 2'h1 : 2'h0;
            r_cnt <= (r_take || r_cnt != 2'h0) ? r_cnt + 2'h1 : 2'h0;
        end
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    a_oe_passes: assert property (O_RD_DATA_OE_N == I_RD_OUT_EN_N)
        else $error("output enable not passed through");
    a_wmark_when: assert property ($changed(O_WR_MARK) |-> w_cnt == 2'h2)
        else $error("write mark moved outside its cycle");
    a_wmark_value: assert property (w_cnt == 2'h2 |-> O_WR_MARK == $past(I_WRITE_ADDRESS_STROBE))
        else $error("write mark not taken at QS0");
    a_rmark_when: assert property ($changed(O_RD_MARK) |-> r_cnt == 2'h2)
        else $error("read mark moved outside its cycle");
    a_rmark_value: assert property (r_cnt == 2'h2 |-> O_RD_MARK == $past(I_READ_ADDRESS_STROBE))
        else $error("read mark not taken at QS0");
    a_valid_cause: assert property (O_RD_DATA_VALID && $past(I_RD_EN_N)
        |-> $past(I_BACK_OFF_ONE_MODE) && $past(r_cnt, 2) == 2'h3)
        else $error("word loaded without a read");
    a_reset_flags: assert property ($past(I_RST) |-> O_EMPTY_FLAG && !O_FULL_FLAG
        && !O_ALMOST_FULL_FLAG && !O_RD_DATA_VALID)
        else $error("flags wrong after reset");
    a_full_almost: assert property (O_FULL_FLAG |-> O_ALMOST_FULL_FLAG)
        else $error("full without almost full");
    c_wr_switch: cover property (w_take);
    c_rd_switch: cover property (r_take && !I_RD_EN_N);
    c_re_present: cover property (O_RD_DATA_VALID && $past(I_RD_EN_N));
endmodule : mqs_top_sva

bind mqs_top mqs_top_sva u_sva (.I_CLK_SYS, .I_RST, .I_DEVICE_IDENTITY_PINS,
    .I_WRITE_QUEUE_ADDRESS_BUS, .I_WRITE_ADDRESS_STROBE, .I_READ_QUEUE_ADDRESS_BUS,
    .I_READ_ADDRESS_STROBE, .I_EMPTY_STATUS_STROBE, .I_RD_EN_N, .I_RD_OUT_EN_N,
    .I_BACK_OFF_ONE_MODE, .O_RD_DATA_VALID, .O_RD_DATA_OE_N, .O_EMPTY_FLAG,
    .O_FULL_FLAG, .O_ALMOST_FULL_FLAG, .O_WR_MARK, .O_RD_MARK);

`default_nettype wire

// File: test/mqs_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module mqs_host_model (
    input  wire logic i_clk,
    output logic      o_oe_n
);
    integer seed = 32'hA2DBF4BF;
    initial o_oe_n = 1'b1;
    // bus drive toggles freely, words keep loading
    always @(posedge i_clk) begin
        o_oe_n <= 1'($random(seed));
    end
endmodule : mqs_host_model

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end

module tb_top;
    localparam logic [2:0] ID = 3'h5;
    logic clk = 1'b0, rst = 1'b1, back_off_one_mode = 1'b0, ws = 1'b0, we_n = 1'b1;
    logic rs = 1'b0, es = 1'b0, re_n = 1'b1, oe_n, oe_o, valid, empty, full, afull;
    logic [9:0] wa = 10'h000, ra = 10'h000, wsa, rsa;
    logic [39:0] wd = 40'h0, rd, got;
    logic [7:0] stat;
    logic [39:0] mq [128][$];
    logic [39:0] last [128];
    logic [39:0] exp [$];
    bit lastv [128];
    logic [6:0] wq = 7'h00, rq = 7'h00, wn, rn, q;
    int wp = 0, rp = 0, num_errors = 0, tests_run = 0;
    bit wu = 1'b1, ru = 1'b1;
    integer seed = 32'hA2DBF4BF;

    mqs_top uut (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1), .I_BACK_OFF_ONE_MODE(back_off_one_mode),
        .I_DEVICE_IDENTITY_PINS(ID), .I_WRITE_QUEUE_ADDRESS_BUS(wa),
        .I_WRITE_ADDRESS_STROBE(ws), .I_WR_EN_N(we_n), .I_WR_DATA(wd),
        .I_READ_QUEUE_ADDRESS_BUS(ra), .I_READ_ADDRESS_STROBE(rs),
        .I_EMPTY_STATUS_STROBE(es), .I_RD_EN_N(re_n), .I_RD_OUT_EN_N(oe_n),
        .O_RD_DATA(rd), .O_RD_DATA_VALID(valid), .O_RD_DATA_OE_N(oe_o),
        .O_EMPTY_FLAG(empty), .O_FULL_FLAG(full), .O_ALMOST_FULL_FLAG(afull),
        .O_ALMOST_EMPTY_STATUS_BUS(stat), .O_WR_MARK(), .O_RD_MARK());
    mqs_host_model u_host (.i_clk(clk), .o_oe_n(oe_n));

    initial forever #20 clk = ~clk;

    // ------------------------------------------------------------
    // one bus cycle on both ports, queue model kept alongside
    // ------------------------------------------------------------
    task automatic cyc(input bit w, input bit r, input bit wsl, input bit rsl, input bit ssl);
        logic [39:0] d;
        d = 40'({$random(seed), $random(seed)});
        @(posedge clk);
        we_n <= !w; wd <= d; ws <= wsl; wa <= wsa;
        re_n <= !r; rs <= rsl; es <= ssl; ra <= rsa;
        if (wp > 0 && --wp == 0) wq = wn;
        if (rp > 0 && --rp == 0) begin
            rq = rn;
            if (back_off_one_mode) begin
                r = 1'b0;
                if (lastv[rq]) exp.push_back(last[rq]);
            end
        end
        // no-rewrite switch: words land but the queue does not grow
        if (w && mq[wq].size() < 4 && (wp == 0 || wu)) mq[wq].push_back(d);
        if (r && mq[rq].size() > 0) begin
            exp.push_back(mq[rq][0]);
            // no-reread switch: word shown, queue keeps it
            if (rp == 0 || ru) begin
                last[rq] = mq[rq][0];
                lastv[rq] = 1'b1;
                void'(mq[rq].pop_front());
            end
        end
        if (wsl && wp == 0 && wsa[9:7] == ID) begin wp = 4; wn = wsa[6:0]; wu = w; end
        if (rsl && !ssl && rp == 0 && rsa[9:7] == ID) begin rp = 4; rn = rsa[6:0]; ru = r; end
    endtask : cyc

    task automatic stat_all();
        logic [7:0] e;
        for (int c = 0; c < 16; c++) begin
            rsa = {2'h0, ID, 1'b1, 4'(c)};
            cyc(0, 0, 0, 0, 1);
            repeat (2) cyc(0, 0, 0, 0, 0);
            #1;
            for (int i = 0; i < 8; i++) e[i] = mq[c * 8 + i].size() <= 1;
            `CHK(stat, e)
        end
    endtask : stat_all

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clk) begin
        if (valid === 1'b1) begin
            got = exp.size() > 0 ? exp.pop_front() : 'x;
            `CHK(rd, got)
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        wsa = 10'h000;
        rsa = 10'h000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(0, 0, 0, 0, 0);
        #1;
        `CHK({empty, full, afull}, 3'b100)
        stat_all();
        $display("test reset done");
        q = 7'($random(seed)) | 7'h01;
        wsa = {~ID, q};
        cyc(1, 0, 1, 0, 0);
        wsa = {ID, q};
        cyc(1, 0, 1, 0, 0);
        repeat (8) cyc(1, 0, 0, 0, 0);
        cyc(0, 0, 0, 0, 0);
        #1;
        `CHK({full, afull}, 2'b11)
        wsa = {ID, 7'h7E};
        cyc(0, 0, 1, 0, 0);
        cyc(0, 0, 0, 0, 0);
        #1;
        `CHK(full, 1'b1)
        repeat (3) cyc(0, 0, 0, 0, 0);
        #1;
        `CHK(full, 1'b0)
        stat_all();
        $display("test write done");
        rsa = {~ID, q};
        cyc(0, 1, 0, 1, 0);
        rsa = {ID, q};
        cyc(0, 1, 0, 1, 0);
        repeat (8) cyc(0, 1, 0, 0, 0);
        repeat (2) cyc(0, 0, 0, 0, 0);
        #1;
        `CHK(empty, 1'b1)
        $display("test read done");
        back_off_one_mode <= 1'b1;
        wsa = {ID, 7'h00};
        rsa = {ID, 7'h00};
        cyc(0, 0, 1, 1, 0);
        repeat (5) cyc(1, 0, 0, 0, 0);
        repeat (3) cyc(0, 1, 0, 0, 0);
        back_off_one_mode <= 1'b0;
        repeat (2) cyc(0, 0, 0, 0, 0);
        #1;
        `CHK(empty, 1'b1)
        `CHK(exp.size(), 0)
        $display("test back-off done");
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
